// >>> design/pulse_autodialer_sequencer.sv
// Function
// RL1: fast rate only if first character marks it
// RL2: each delay character pauses one second
// RL3: other non-digit characters skipped, no line action
// RL4: dial string holds at most 500 characters
// RL5: control value 2 queues string load block
// RL6: string queued behind block, entries in order
// RL7: control value 1 queues start-connection block
// RL8: drop line two seconds, settle 500 ms
// RL9: characters dialed one by one in order
// RL10: click and click gap lengths per rate
// RL11: number gap 700 or 300 ms
// RL12: digit n gives n clicks, zero ten
// RL13: status reads 2 dialing, 1 trying, 3 connected
// RL14: unarmed start connects directly, no dialing
// RL15: host polls status before moving data
// RL16: line closed outside clicks, completion reported
`timescale 1ns/1ps
`default_nettype none
module pulse_autodialer_sequencer #(
   parameter int          QDEPTH = dialer_pkg::Q_DEPTH,
   parameter int unsigned TICKS  = dialer_pkg::TICK_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   output var  logic        irq,
   output var  logic        line_break,
   output var  logic        line_off_hook,
   output var  logic        direct_connect,
   input  wire logic        line_ready
);
   import dialer_pkg::*;

   localparam int QAW = $clog2(QDEPTH);
   localparam int QCW = $clog2(QDEPTH + 1);

   dial_if dl ();

   pulse_dialer #(
      .TICKS   (TICKS),
      .MAX_LEN (MAX_DIAL_LEN)
   ) u_dialer (
      .clock         (clock),
      .rst_b         (rst_b),
      .d             (dl.dialer),
      .line_break    (line_break),
      .line_off_hook (line_off_hook)
   );

   // outbound queue entry: {control flag, byte}
   logic [8:0]       q_mem [QDEPTH];
   logic [QAW-1:0]   wr_ptr_reg;
   logic [QAW-1:0]   rd_ptr_reg;
   logic [QCW-1:0]   count_reg;
   logic [8:0]       head;
   logic             push;
   logic             pop;
   logic             q_full;
   logic [8:0]       push_data;

   logic             ack_reg;
   logic [31:0]      dat_reg;
   logic             req;
   logic             wr_fire;
   logic             rd_fire;

   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] events;
   logic [1:0]       conn_reg;
   logic             armed_reg;
   logic             loading_reg;
   logic             direct_reg;
   logic             is_ctrl;

   function automatic logic [QAW-1:0] ptr_inc(input logic [QAW-1:0] p);
      ptr_inc = (p == QAW'(QDEPTH - 1)) ? '0 : p + QAW'(1);
   endfunction : ptr_inc

   function automatic logic hits(input logic [7:0] a, input logic [7:0] r);
      hits = (a == r);
   endfunction : hits

   // writes and read side effects land on the edge that sees ack high
   assign req      = wb_cyc_i && wb_stb_i;
   assign wr_fire  = req && wb_we_i && ack_reg;
   assign rd_fire  = req && !wb_we_i && ack_reg;
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= req && !ack_reg;
         if (req && !ack_reg && !wb_we_i) begin
            dat_reg <= '0;
            if (hits(wb_adr_i, ADDR_IRQ_STAT)) begin
               dat_reg[IRQ_W-1:0] <= irq_stat_reg | events;
            end else if (hits(wb_adr_i, ADDR_IRQ_MASK)) begin
               dat_reg[IRQ_W-1:0] <= irq_mask_reg;
            end else if (hits(wb_adr_i, ADDR_CONN)) begin
               dat_reg[1:0] <= conn_reg; // [RL13]
            end else if (hits(wb_adr_i, ADDR_DIAL_STAT)) begin
               dat_reg[DS_ARMED]   <= armed_reg;
               dat_reg[DS_LOADING] <= loading_reg;
               dat_reg[DS_BUSY]    <= dl.busy;
               dat_reg[DS_FAST]    <= dl.fast;
               dat_reg[DS_LEN_LSB +: LEN_W] <= dl.len;
            end
         end
      end
   end

   // queue fill: string bytes and the two control blocks
   assign is_ctrl = hits(wb_adr_i, ADDR_CONN);
   assign push_data = {is_ctrl, wb_dat_i[7:0]};
   assign q_full    = (count_reg == QCW'(QDEPTH));
   assign push = wr_fire && wb_sel_i[0] && !q_full
                 && (hits(wb_adr_i, ADDR_TX_DATA)
                     || (is_ctrl && (wb_dat_i[7:0] == CMD_START_CONN
                         || wb_dat_i[7:0] == CMD_START_DIAL))); // [RL5]
   assign head = q_mem[rd_ptr_reg];
   // the head waits while a dial runs so later blocks keep their order
   assign pop  = (count_reg != '0) && !dl.busy; // [RL6]

   always_ff @(posedge clock) begin
      if (push) begin
         q_mem[wr_ptr_reg] <= push_data; // [RL6]
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
         end
         if (pop) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
         end
         count_reg <= count_reg + QCW'(push) - QCW'(pop);
      end
   end

   // queue entry handling toward the dialer
   assign dl.clear = pop && head[8] && head[7:0] == CMD_START_DIAL;
   assign dl.load_valid = pop && !head[8] && loading_reg; // [RL5]
   assign dl.load_char  = head[7:0];
   assign dl.start = pop && head[8] && head[7:0] == CMD_START_CONN
                     && armed_reg; // [RL8]

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         armed_reg   <= 1'b0;
         loading_reg <= 1'b0;
         direct_reg  <= 1'b0;
      end else if (pop && head[8]) begin
         loading_reg <= 1'b0;
         if (head[7:0] == CMD_START_DIAL) begin
            armed_reg   <= 1'b1; // [RL5]
            loading_reg <= 1'b1;
         end else if (head[7:0] == CMD_START_CONN) begin
            armed_reg <= 1'b0;
            if (!armed_reg) begin
               direct_reg <= 1'b1; // [RL14]
            end
         end
      end
   end

   assign direct_connect = direct_reg;

   // connection progress; unarmed path waits for the line to answer
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         conn_reg <= CONN_IDLE;
      end else if (pop && head[8] && head[7:0] == CMD_START_CONN) begin
         conn_reg <= CONN_TRYING; // [RL7]
      end else if (dl.done) begin
         conn_reg <= CONN_DONE; // [RL16]
      end else if (dl.dialing) begin
         conn_reg <= CONN_DIALING; // [RL13]
      end else if (direct_reg && line_ready && conn_reg == CONN_TRYING) begin
         conn_reg <= CONN_DONE; // [RL14]
      end
   end

   // a new event outranks the clear-on-read of the same cycle
   assign events[IRQ_DIAL_DONE] = dl.done;
   assign events[IRQ_CONNECTED] = (conn_reg != CONN_DONE)
      && (dl.done || (direct_reg && line_ready
                      && conn_reg == CONN_TRYING));
   assign events[IRQ_STR_OVF] = dl.overflow; // [RL4]
   assign events[IRQ_Q_OVF]   = wr_fire && q_full
      && (hits(wb_adr_i, ADDR_TX_DATA) || is_ctrl);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         irq_stat_reg <= ((rd_fire && hits(wb_adr_i, ADDR_IRQ_STAT))
                          ? '0 : irq_stat_reg) | events;
         if (wr_fire && wb_sel_i[0] && hits(wb_adr_i, ADDR_IRQ_MASK)) begin
            irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : pulse_autodialer_sequencer
`default_nettype wire

// >>> design/dialer_pkg.sv
package dialer_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_TX_DATA   = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h08;
   localparam logic [7:0] ADDR_CONN      = 8'h0c;
   localparam logic [7:0] ADDR_DIAL_STAT = 8'h10;
   // connection control values
   localparam logic [7:0] CMD_START_CONN = 8'h01;
   localparam logic [7:0] CMD_START_DIAL = 8'h02;
   // connection status values
   localparam logic [1:0] CONN_IDLE      = 2'h0;
   localparam logic [1:0] CONN_TRYING    = 2'h1;
   localparam logic [1:0] CONN_DIALING   = 2'h2;
   localparam logic [1:0] CONN_DONE      = 2'h3;
   // interrupt status / mask bit positions
   localparam int IRQ_W         = 4;
   localparam int IRQ_DIAL_DONE = 0;
   localparam int IRQ_CONNECTED = 1;
   localparam int IRQ_STR_OVF   = 2;
   localparam int IRQ_Q_OVF     = 3;
   // dial status field positions
   localparam int DS_ARMED   = 0;
   localparam int DS_LOADING = 1;
   localparam int DS_BUSY    = 2;
   localparam int DS_FAST    = 3;
   localparam int DS_LEN_LSB = 16;
   // dial string characters
   localparam logic [7:0] CH_FAST  = 8'h3e;
   localparam logic [7:0] CH_DELAY = 8'h40;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_NINE  = 8'h39;
   // sizes
   localparam int MAX_DIAL_LEN = 500;
   localparam int LEN_W        = 9;
   localparam int Q_DEPTH      = 512;
   // timing: one tick is half a millisecond
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned TICK_US       = 500;
   localparam int unsigned TICK_CYCLES   =
      TICK_US * 1000000 / CLK_PERIOD_PS;
   localparam int unsigned CLICK_SLOW_US = 60000;
   localparam int unsigned GAP_SLOW_US   = 40000;
   localparam int unsigned NGAP_SLOW_US  = 700000;
   localparam int unsigned CLICK_FAST_US = 32500;
   localparam int unsigned GAP_FAST_US   = 17500;
   localparam int unsigned NGAP_FAST_US  = 300000;
   localparam int unsigned DELAY_US      = 1000000;
   localparam int unsigned SETTLE_US     = 500000;
   localparam int unsigned DROP_US       = 2000000;
   localparam int TW = 13;
   localparam logic [TW-1:0] T_CLICK_SLOW = TW'(CLICK_SLOW_US / TICK_US);
   localparam logic [TW-1:0] T_GAP_SLOW   = TW'(GAP_SLOW_US / TICK_US);
   localparam logic [TW-1:0] T_NGAP_SLOW  = TW'(NGAP_SLOW_US / TICK_US);
   localparam logic [TW-1:0] T_CLICK_FAST = TW'(CLICK_FAST_US / TICK_US);
   localparam logic [TW-1:0] T_GAP_FAST   = TW'(GAP_FAST_US / TICK_US);
   localparam logic [TW-1:0] T_NGAP_FAST  = TW'(NGAP_FAST_US / TICK_US);
   localparam logic [TW-1:0] T_DELAY      = TW'(DELAY_US / TICK_US);
   localparam logic [TW-1:0] T_SETTLE     = TW'(SETTLE_US / TICK_US);
   localparam logic [TW-1:0] T_DROP       = TW'(DROP_US / TICK_US);
endpackage : dialer_pkg

// >>> design/dial_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dial_if;
   import dialer_pkg::*;
   logic             clear;
   logic             load_valid;
   logic [7:0]       load_char;
   logic             start;
   logic             busy;
   logic             dialing;
   logic             done;
   logic             overflow;
   logic             fast;
   logic [LEN_W-1:0] len;
   modport ctrl (output clear, load_valid, load_char, start,
                 input busy, dialing, done, overflow, fast, len);
   modport dialer (input clear, load_valid, load_char, start,
                   output busy, dialing, done, overflow, fast, len);
endinterface : dial_if
`default_nettype wire

// >>> design/pulse_dialer.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_dialer
   import dialer_pkg::*;
#(
   parameter int unsigned TICKS   = dialer_pkg::TICK_CYCLES,
   parameter int          MAX_LEN = dialer_pkg::MAX_DIAL_LEN
) (
   input  wire logic clock,
   input  wire logic rst_b,
   dial_if.dialer    d,
   output var  logic line_break,
   output var  logic line_off_hook
);
   typedef enum logic [7:0] {
      S_IDLE   = 8'b0000_0001,
      S_DROP   = 8'b0000_0010,
      S_SETTLE = 8'b0000_0100,
      S_FETCH  = 8'b0000_1000,
      S_CLICK  = 8'b0001_0000,
      S_CGAP   = 8'b0010_0000,
      S_NGAP   = 8'b0100_0000,
      S_WAIT   = 8'b1000_0000
   } dial_state_t;

   dial_state_t      state_reg;
   logic [7:0]       str_mem [MAX_LEN];
   logic [LEN_W-1:0] len_reg;
   logic [LEN_W-1:0] ptr_reg;
   logic [31:0]      div_reg;
   logic [TW-1:0]    timer_reg;
   logic [3:0]       clicks_reg;
   logic             fast_reg;
   logic             need_gap_reg;
   logic             off_hook_reg;
   logic             tick;
   logic             expired;
   logic [7:0]       ch;

   assign tick    = (div_reg == TICKS - 1);
   assign expired = tick && (timer_reg == TW'(1));
   assign ch      = str_mem[ptr_reg];

   assign d.busy     = (state_reg != S_IDLE);
   assign d.dialing  = d.busy && (state_reg != S_DROP)
                       && (state_reg != S_SETTLE);
   assign d.done     = (state_reg == S_FETCH) && (ptr_reg == len_reg);
   assign d.overflow = d.load_valid && (len_reg == LEN_W'(MAX_LEN));
   assign d.fast     = fast_reg;
   assign d.len      = len_reg;
   assign line_break    = state_reg[4]; // [RL16]
   assign line_off_hook = off_hook_reg;

   // string store; extra characters past the limit are dropped
   always_ff @(posedge clock) begin
      if (d.load_valid && (len_reg < LEN_W'(MAX_LEN))) begin // [RL4]
         str_mem[len_reg] <= d.load_char;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         len_reg <= '0;
      end else if (d.clear) begin
         len_reg <= '0;
      end else if (d.load_valid && (len_reg < LEN_W'(MAX_LEN))) begin
         len_reg <= len_reg + LEN_W'(1);
      end
   end

   // divider restarts with every timed state so each interval is exact
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= S_IDLE;
         ptr_reg      <= '0;
         div_reg      <= '0;
         timer_reg    <= '0;
         clicks_reg   <= '0;
         fast_reg     <= 1'b0;
         need_gap_reg <= 1'b0;
         off_hook_reg <= 1'b0;
      end else begin
         div_reg <= tick ? '0 : div_reg + 32'd1;
         if (tick && timer_reg != '0) begin
            timer_reg <= timer_reg - TW'(1);
         end
         case (state_reg)
            S_IDLE: begin
               if (d.start) begin // [RL8]
                  state_reg    <= S_DROP;
                  off_hook_reg <= 1'b0;
                  timer_reg    <= T_DROP;
                  div_reg      <= '0;
                  ptr_reg      <= '0;
                  fast_reg     <= 1'b0;
                  need_gap_reg <= 1'b0;
               end
            end
            S_DROP: begin
               if (expired) begin // [RL8]
                  state_reg    <= S_SETTLE;
                  off_hook_reg <= 1'b1;
                  timer_reg    <= T_SETTLE;
                  div_reg      <= '0;
               end
            end
            S_SETTLE: begin
               if (expired) begin
                  state_reg <= S_FETCH; // [RL8]
               end
            end
            S_FETCH: begin
               div_reg <= '0;
               if (ptr_reg == len_reg) begin
                  state_reg <= S_IDLE; // [RL16]
               end else begin
                  ptr_reg <= ptr_reg + LEN_W'(1); // [RL9]
                  if (ptr_reg == '0 && ch == CH_FAST) begin
                     fast_reg <= 1'b1; // [RL1]
                  end else if (ch == CH_DELAY) begin
                     state_reg <= S_WAIT; // [RL2]
                     timer_reg <= T_DELAY;
                  end else if (ch >= CH_ZERO && ch <= CH_NINE) begin
                     clicks_reg <= (ch == CH_ZERO) ? 4'd10
                                   : ch[3:0]; // [RL12]
                     if (need_gap_reg) begin
                        state_reg <= S_NGAP; // [RL11]
                        timer_reg <= fast_reg ? T_NGAP_FAST : T_NGAP_SLOW;
                     end else begin
                        state_reg <= S_CLICK;
                        timer_reg <= fast_reg ? T_CLICK_FAST
                                     : T_CLICK_SLOW; // [RL10]
                     end
                  end
                  // any other character is skipped [RL3]
               end
            end
            S_CLICK: begin
               if (expired) begin
                  div_reg <= '0;
                  if (clicks_reg == 4'd1) begin
                     need_gap_reg <= 1'b1;
                     state_reg    <= S_FETCH;
                  end else begin
                     clicks_reg <= clicks_reg - 4'd1;
                     state_reg  <= S_CGAP;
                     timer_reg  <= fast_reg ? T_GAP_FAST
                                   : T_GAP_SLOW; // [RL10]
                  end
               end
            end
            S_CGAP, S_NGAP: begin
               if (expired) begin
                  need_gap_reg <= 1'b0;
                  state_reg    <= S_CLICK;
                  div_reg      <= '0;
                  timer_reg    <= fast_reg ? T_CLICK_FAST : T_CLICK_SLOW;
               end
            end
            S_WAIT: begin
               if (expired) begin
                  state_reg <= S_FETCH;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule : pulse_dialer
`default_nettype wire

// >>> test/dialer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dialer_checker #(
   parameter int unsigned TICKS = 4
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic irq,
   input wire logic line_break,
   input wire logic line_off_hook,
   input wire logic direct_connect
);
   int unsigned hi_cnt;
   int unsigned lo_cnt;
   int unsigned hk_cnt;
   // run lengths of break high, break low, and line held
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt <= 0;
         lo_cnt <= 0;
         hk_cnt <= 0;
      end else begin
         hi_cnt <= line_break ? hi_cnt + 1 : 0;
         lo_cnt <= line_break ? 0 : lo_cnt + 1;
         hk_cnt <= line_off_hook ? hk_cnt + 1 : 0;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("no ack one cycle after request");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_idle_ack;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_idle_ack: assert property (p_idle_ack)
      else $error("ack without request");
   property p_break_hook;
      line_break |-> line_off_hook;
   endproperty
   a_break_hook: assert property (p_break_hook)
      else $error("click while line dropped");
   property p_click_len;
      $fell(line_break) |-> hi_cnt == 120 * TICKS || hi_cnt == 65 * TICKS;
   endproperty
   a_click_len: assert property (p_click_len)
      else $error("click length wrong");
   property p_gap_len;
      $rose(line_break) |-> lo_cnt == 80 * TICKS || lo_cnt == 35 * TICKS
         || lo_cnt >= 600 * TICKS;
   endproperty
   a_gap_len: assert property (p_gap_len)
      else $error("gap before click wrong");
   property p_settle;
      $rose(line_break) |-> hk_cnt >= 1000 * TICKS;
   endproperty
   a_settle: assert property (p_settle)
      else $error("click before settle time");
   property p_hook_drop;
      $fell(line_off_hook) |-> !line_off_hook [*8];
   endproperty
   a_hook_drop: assert property (p_hook_drop)
      else $error("line drop too short");
   property p_direct_quiet;
      $rose(direct_connect) |-> !line_break [*8];
   endproperty
   a_direct_quiet: assert property (p_direct_quiet)
      else $error("clicks on direct connection");
   c_click: cover property ($rose(line_break));
   c_direct: cover property ($rose(direct_connect));
   c_irq: cover property ($rose(irq));
endmodule : dialer_checker
bind pulse_autodialer_sequencer dialer_checker #(.TICKS(TICKS)) u_chk (
   .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq),
   .line_break(line_break), .line_off_hook(line_off_hook),
   .direct_connect(direct_connect));
`default_nettype wire

// >>> test/line_model.sv
`timescale 1ns/1ps
`default_nettype none
module line_model #(
   parameter int unsigned TICKS   = 4,
   parameter int unsigned ANS_DLY = 40
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic line_break,
   input  wire logic direct_connect,
   output var  logic line_ready
);
   byte         digits[$];
   int          pend;
   int unsigned wid;
   int unsigned hi;
   int unsigned lo;
   int unsigned ans;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pend = 0;
         hi = 0;
         lo = 0;
         ans = 0;
         line_ready <= 1'b0;
      end else begin
         if (line_break) begin
            hi = hi + 1;
            lo = 0;
         end else begin
            if (hi != 0) begin
               pend = pend + 1;
               wid = hi;
            end
            hi = 0;
            lo = lo + 1;
            // exchange reads a digit once the pause outlasts a click gap
            if (pend != 0 && lo == 300 * TICKS) begin
               digits.push_back(byte'(8'h30 + pend % 10));
               pend = 0;
            end
         end
         if (direct_connect && ans < ANS_DLY) ans = ans + 1;
         line_ready <= (ans == ANS_DLY);
      end
   end
endmodule : line_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dialer_pkg::*;
   localparam int unsigned TK = 4;
   typedef struct {
      string s;
      string dig;
      int    wid;
      int    pre;
   } row_t;
   logic        clock, rst_b, cyc, stb, we, ack, irq, brk, hook, dconn;
   logic        ready, hook_q, seen2;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [3:0]  sel;
   int          n_fail, n_tests, cyc_n, t_go, t_hook, t_brk, n;
   string       got;
   row_t        rows[2];
   pulse_autodialer_sequencer #(.QDEPTH(16), .TICKS(TK)) DUT (
      .clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .line_break(brk),
      .line_off_hook(hook), .direct_connect(dconn), .line_ready(ready));
   line_model #(.TICKS(TK)) line (.clock(clock), .rst_b(rst_b),
      .line_break(brk), .direct_connect(dconn), .line_ready(ready));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc_n++;
      if (hook && !hook_q) t_hook = cyc_n;
      if (brk && t_brk < 0) t_brk = cyc_n;
      hook_q = hook;
   end
   task automatic stop_test;
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clock);
         k++;
      end while (ack !== 1'b1 && k < 100);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 100) n_fail++;
   endtask : wb
   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd_chk
   initial begin
      repeat (90000) @(posedge clock);
      n_fail++;
      stop_test();
   end
   initial begin
      {rst_b, cyc, stb, we, adr, wdat, hook_q} = '0;
      sel = 4'hf;
      {n_fail, n_tests, cyc_n} = '0;
      rows[0] = '{"@ (>5)", "5", 120, 3000};
      rows[1] = '{">0-9", "09", 65, 1000};
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      wb(1'b1, ADDR_IRQ_MASK, 32'hf);
      foreach (rows[i]) begin
         wb(1'b1, ADDR_TX_DATA, 32'h37);
         wb(1'b1, ADDR_CONN, {24'h0, CMD_START_DIAL});
         for (int k = 0; k < rows[i].s.len(); k++)
            wb(1'b1, ADDR_TX_DATA, {24'h0, rows[i].s[k]});
         wb(1'b0, ADDR_DIAL_STAT, 32'h0);
         n = rows[i].s.len();
         q = q & 32'h01ff0003;
         chk("armed", (32'(n) << DS_LEN_LSB) | 32'h3, q);
         line.digits.delete();
         t_brk = -1;
         wb(1'b1, ADDR_CONN, {24'h0, CMD_START_CONN});
         t_go = cyc_n;
         rd_chk("trying", ADDR_CONN, 32'h1);
         seen2 = 1'b0;
         n = 0;
         do begin
            wb(1'b0, ADDR_CONN, 32'h0);
            if (q === 32'h2) seen2 = 1'b1;
            n++;
         end while (q !== 32'h3 && n < 20000);
         chk("dialing", 1, seen2);
         chk("connected", 3, q);
         n = t_hook - t_go - 4000 * TK;
         chk("drop", 1, 32'(n >= -2 && n <= 12));
         n = t_brk - t_hook - rows[i].pre * TK;
         chk("pre_wait", 1, 32'(n >= -2 && n <= 16));
         n = 0;
         while (line.pend != 0 && n < 2000) begin
            @(posedge clock);
            n++;
         end
         got = "";
         foreach (line.digits[j]) got = {got, string'(line.digits[j])};
         chk("digits", 1, 32'(got == rows[i].dig));
         chk("click", rows[i].wid * TK, line.wid);
         chk("irq_set", 1, irq);
         rd_chk("irq_stat", ADDR_IRQ_STAT, 32'h3);
         rd_chk("stat_clr", ADDR_IRQ_STAT, 32'h0);
         chk("irq_clr", 0, irq);
      end
      wb(1'b1, ADDR_CONN, {24'h0, CMD_START_DIAL});
      repeat (MAX_DIAL_LEN + 1) wb(1'b1, ADDR_TX_DATA, 32'h2d);
      wb(1'b0, ADDR_DIAL_STAT, 32'h0);
      // armed and loading from the new start-dial block, fast rate left over from the last dial
      q = q & 32'h01ff000f;
      chk("len_cap", (32'(MAX_DIAL_LEN) << DS_LEN_LSB) | 32'hb, q);
      rd_chk("str_ovf", ADDR_IRQ_STAT, 32'h4);
      rd_chk("unmapped", 8'h20, 32'h0);
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (2) @(posedge clock);
      chk("rst_out", 0, 32'({ack, irq, brk, hook, dconn}));
      rst_b <= 1'b1;
      rd_chk("rst_mask", ADDR_IRQ_MASK, 32'h0);
      rd_chk("rst_dial", ADDR_DIAL_STAT, 32'h0);
      wb(1'b1, ADDR_CONN, 32'h3);
      rd_chk("bad_cmd", ADDR_CONN, 32'h0);
      wb(1'b1, ADDR_CONN, {24'h0, CMD_START_CONN});
      rd_chk("direct_try", ADDR_CONN, 32'h1);
      chk("direct", 1, dconn);
      n = 0;
      do begin
         wb(1'b0, ADDR_CONN, 32'h0);
         n++;
      end while (q !== 32'h3 && n < 200);
      chk("direct_conn", 3, q);
      chk("masked", 0, irq);
      wb(1'b1, ADDR_IRQ_MASK, 32'h2);
      @(posedge clock);
      chk("unmasked", 1, irq);
      rd_chk("direct_stat", ADDR_IRQ_STAT, 32'h2);
      @(posedge clock);
      chk("irq_off", 0, irq);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
